/* File: src/dac_reference_control.sv */
// apb register block and steering for the 8-bit reference level generator
`timescale 1ns/100ps
module dac_reference_control
#(
    parameter int CODE_W = dac_ref_pkg::CODE_WIDTH
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               sleep_wake,
    input  wire logic               port_one_out,
    input  wire logic               port_one_oe,
    input  wire logic               pin_one_in,
    input  wire logic               port_two_out,
    input  wire logic               port_two_oe,
    input  wire logic               pin_two_in,
    output logic                    level_pin_one_out,
    output logic                    level_pin_one_oe,
    output logic                    level_pin_one_rd,
    output logic                    level_pin_two_out,
    output logic                    level_pin_two_oe,
    output logic                    level_pin_two_rd,
    output logic                    level_pin_one,
    output logic                    level_pin_two,
    output logic                    level_gen_active,
    output logic      [CODE_W-1:0]  level_code_out,
    output logic      [1:0]         positive_source_out,
    output logic                    negative_source_out,
    output logic                    level_to_consumers,
    output logic                    opamp_enable_out,
    output logic                    sleeping
);
    import dac_ref_pkg::*;

    logic [7:0]        level_control_zero;
    logic [CODE_W-1:0] level_code_register;
    logic [7:0]        opamp_control;
    logic              sleep_state;
    logic              wr_en;
    logic              rd_en;
    logic              addr_ok;
    logic [31:0]       next_prdata;

    // decode once, used for both directions
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_CONTROL_ZERO) || (a == ADDR_LEVEL_CODE) ||
                 (a == ADDR_OPAMP_CTRL) || (a == ADDR_SLEEP_CTRL);
    endfunction

    // apb writes in access phase, reads captured in setup, zero wait states
    assign addr_ok = mapped(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;

    // control register zero; unimplemented bits never stored
    // sleep and wake do not touch it, only reset and writes do
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_control_zero <= RESET_BYTE;
        end else if (wr_en && paddr == ADDR_CONTROL_ZERO) begin
            level_control_zero <= pwdata[7:0] & CONTROL_ZERO_IMPL;
        end
    end

    // level code register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_code_register <= CODE_W'(0);
        end else if (wr_en && paddr == ADDR_LEVEL_CODE) begin
            level_code_register <= pwdata[CODE_W-1:0];
        end
    end

    // op amp control, only the enable bit implemented
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opamp_control <= RESET_BYTE;
        end else if (wr_en && paddr == ADDR_OPAMP_CTRL) begin
            opamp_control <= pwdata[7:0] & OPAMP_MASK;
        end
    end

    // sleep flag: set by software, cleared by wake; registers retained
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_state <= 1'b0;
        end else if (sleep_wake) begin
            sleep_state <= 1'b0;
        end else if (wr_en && paddr == ADDR_SLEEP_CTRL) begin
            sleep_state <= pwdata[BIT_SLEEP];
        end
    end

    // read mux prepared in setup so prdata is a flop at access
    always_comb begin
        next_prdata = ZERO_WORD;
        case (paddr)
            ADDR_CONTROL_ZERO: next_prdata[7:0] = level_control_zero & CONTROL_ZERO_IMPL;
            ADDR_LEVEL_CODE:   next_prdata[CODE_W-1:0] = level_code_register;
            ADDR_OPAMP_CTRL:   next_prdata[7:0] = opamp_control;
            ADDR_SLEEP_CTRL:   next_prdata[BIT_SLEEP] = sleep_state;
            default:           next_prdata = ZERO_WORD;
        endcase
    end

    // bus answer: ready every access, error on unmapped address
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && !mapped(paddr);
            if (rd_en) begin
                prdata <= next_prdata;
            end
        end
    end

    // steering outputs toward the analog ladder and its consumers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_gen_active    <= 1'b0;
            level_code_out      <= CODE_W'(0);
            positive_source_out <= POS_SUPPLY;
            negative_source_out <= 1'b0;
            level_to_consumers  <= 1'b0;
            opamp_enable_out    <= 1'b0;
            sleeping            <= 1'b0;
        end else begin
            level_gen_active    <= level_control_zero[BIT_ENABLE];
            // ladder taps: vneg + code/2^8 * (vpos - vneg)
            level_code_out      <= level_code_register;
            // reserved code passes through; software must not use it
            positive_source_out <= level_control_zero[BIT_PSS_HI:BIT_PSS_LO];
            negative_source_out <= level_control_zero[BIT_NSS];
            level_to_consumers  <= level_control_zero[BIT_ENABLE];
            opamp_enable_out    <= opamp_control[BIT_OPAMP_EN];
            sleeping            <= sleep_state;
        end
    end

    // pin override only while the generator runs
    logic sel_one;
    logic sel_two;
    assign sel_one = level_control_zero[BIT_ENABLE]
                  && level_control_zero[BIT_PIN_ONE];
    assign sel_two = level_control_zero[BIT_ENABLE]
                  && level_control_zero[BIT_PIN_TWO];

    level_pin_mux u_pin_one (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .analog_sel     (sel_one),
        .port_out       (port_one_out),
        .port_oe        (port_one_oe),
        .pin_in         (pin_one_in),
        .pin_out        (level_pin_one_out),
        .pin_oe         (level_pin_one_oe),
        .pin_rd         (level_pin_one_rd),
        .analog_connect (level_pin_one)
    );

    level_pin_mux u_pin_two (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .analog_sel     (sel_two),
        .port_out       (port_two_out),
        .port_oe        (port_two_oe),
        .pin_in         (pin_two_in),
        .pin_out        (level_pin_two_out),
        .pin_oe         (level_pin_two_oe),
        .pin_rd         (level_pin_two_rd),
        .analog_connect (level_pin_two)
    );
endmodule // dac_reference_control

/* File: src/dac_ref_pkg.sv */
// shared constants for the reference level generator control block
package dac_ref_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] ADDR_CONTROL_ZERO = 12'h000;
    localparam logic [11:0] ADDR_LEVEL_CODE   = 12'h004;
    localparam logic [11:0] ADDR_OPAMP_CTRL   = 12'h008;
    localparam logic [11:0] ADDR_SLEEP_CTRL   = 12'h00C;
    // field positions in control register zero, op amp control and sleep control
    localparam int BIT_ENABLE    = 7;
    localparam int BIT_PIN_ONE   = 5;
    localparam int BIT_PIN_TWO   = 4;
    localparam int BIT_PSS_HI    = 3;
    localparam int BIT_PSS_LO    = 2;
    localparam int BIT_NSS       = 0;
    localparam int BIT_OPAMP_EN  = 7;
    localparam int BIT_SLEEP     = 0;
    // writable bits; bits 6 and 1 are unimplemented
    localparam logic [7:0] CONTROL_ZERO_MASK = 8'h3D;
    localparam logic [7:0] CONTROL_ZERO_IMPL = 8'hBD;
    localparam logic [7:0] OPAMP_MASK        = 8'h80;
    localparam logic [7:0] RESET_BYTE        = 8'h00;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
    // positive source encodings
    typedef enum logic [1:0] {
        POS_SUPPLY   = 2'b00,
        POS_EXT_PIN  = 2'b01,
        POS_FIXED    = 2'b10,
        POS_RESERVED = 2'b11
    } pos_source_t;
    // width of the level code and number of levels
    localparam int CODE_WIDTH = 8;
    localparam int LEVEL_COUNT = 256;
endpackage

/* File: src/level_pin_mux.sv */
// per-pin override between the level output and the digital port buffer
`timescale 1ns/100ps
module level_pin_mux (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic analog_sel,
    input  wire logic port_out,
    input  wire logic port_oe,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pin_rd,
    output logic      analog_connect
);
    // registered so every top output comes straight from a flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out        <= 1'b0;
            pin_oe         <= 1'b0;
            pin_rd         <= 1'b0;
            analog_connect <= 1'b0;
        end else begin
            analog_connect <= analog_sel;
            pin_oe         <= analog_sel ? 1'b0 : port_oe;
            pin_out        <= analog_sel ? 1'b0 : port_out;
            pin_rd         <= analog_sel ? 1'b0 : pin_in;
        end
    end
endmodule // level_pin_mux

/* File: testbench/dac_ref_sva.sv */
// port checker for the reference level control block
`timescale 1ns/100ps
module dac_ref_sva
    import dac_ref_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        level_gen_active,
    input wire logic        level_to_consumers,
    input wire logic        level_pin_one,
    input wire logic        level_pin_two,
    input wire logic        level_pin_one_out,
    input wire logic        level_pin_one_oe,
    input wire logic        level_pin_one_rd,
    input wire logic [1:0]  positive_source_out,
    input wire logic        opamp_enable_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic mapped;
    // decode of the four word addresses
    assign mapped = paddr inside {ADDR_CONTROL_ZERO, ADDR_LEVEL_CODE, ADDR_OPAMP_CTRL,
                                  ADDR_SLEEP_CTRL};
    sequence acc_s; psel && penable; endsequence
    sequence wr0_s; acc_s ##0 (pwrite && paddr == ADDR_CONTROL_ZERO); endsequence
    // lag of one to three cycles allowed for the derived outputs
    ready_always_a: assert property (pready) else $error("pready low");
    upper_zero_a: assert property (prdata[31:8] == '0) else $error("upper read bits set");
    unmapped_err_a: assert property (acc_s ##0 !mapped |-> pslverr) else $error("no slverr");
    mapped_ok_a: assert property (acc_s ##0 mapped |-> !pslverr) else $error("false slverr");
    unimpl_read_a: assert property (acc_s ##0 (!pwrite && paddr == ADDR_CONTROL_ZERO)
        |-> !prdata[6] && !prdata[1]) else $error("unused bits read one");
    enable_set_a: assert property (wr0_s ##0 pwdata[7] |-> ##[1:3] level_gen_active)
        else $error("enable not taken");
    enable_clr_a: assert property (wr0_s ##0 !pwdata[7] |-> ##[1:3] !level_gen_active)
        else $error("disable not taken");
    source_fix_a: assert property (wr0_s ##0 pwdata[3:2] == 2'b10
        |-> ##[1:3] positive_source_out == 2'b10) else $error("source wrong");
    pin_gated_a: assert property (!level_gen_active [*3]
        |-> !level_pin_one && !level_pin_two) else $error("pin level while off");
    pin_override_a: assert property (level_pin_one
        |-> !level_pin_one_out && !level_pin_one_oe && !level_pin_one_rd)
        else $error("digital buffer live");
    consumers_a: assert property (level_to_consumers == level_gen_active)
        else $error("consumer feed differs");
    opamp_on_a: assert property (acc_s ##0 pwrite
        ##0 (paddr == ADDR_OPAMP_CTRL && pwdata[7]) |-> ##[1:3] opamp_enable_out)
        else $error("op amp not on");
endmodule // dac_ref_sva
bind dac_reference_control dac_ref_sva dac_ref_sva_i (.mclk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .level_gen_active, .level_to_consumers,
    .level_pin_one, .level_pin_two, .level_pin_one_out, .level_pin_one_oe, .level_pin_one_rd,
    .positive_source_out, .opamp_enable_out);

/* File: testbench/tb.sv */
// register level testbench for the reference level control block
`timescale 1ns/100ps
module tb;
    import dac_ref_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_wake = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, p1o = 1, p1e = 1, p1i = 1, p2o = 0, p2e = 1, p2i = 1;
    logic l1o, l1e, l1r, l2o, l2e, l2r, lp1, lp2, act, neg, cons, opa, slp;
    logic [7:0] code;
    logic [1:0] pos;
    int err_count = 0, compares = 0;
    logic [7:0] rd_codes [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
    dac_reference_control dac_reference_control_i (.mclk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_wake, .port_one_out(p1o),
        .port_one_oe(p1e), .pin_one_in(p1i), .port_two_out(p2o), .port_two_oe(p2e),
        .pin_two_in(p2i), .level_pin_one_out(l1o), .level_pin_one_oe(l1e),
        .level_pin_one_rd(l1r), .level_pin_two_out(l2o), .level_pin_two_oe(l2e),
        .level_pin_two_rd(l2r), .level_pin_one(lp1), .level_pin_two(lp2),
        .level_gen_active(act), .level_code_out(code), .positive_source_out(pos),
        .negative_source_out(neg), .level_to_consumers(cons), .opamp_enable_out(opa),
        .sleeping(slp));
    initial forever #2.5 mclk = ~mclk;
    // one apb transfer; waits on pready, the watchdog cuts a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, '0);
        chk(n, e, rd);
    endtask
    // outputs settle one cycle after the access edge, settle waits three
    task settle; repeat (3) @(posedge mclk); endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1;
        rdchk("ctrl0 reset", ADDR_CONTROL_ZERO, '0);
        rdchk("code reset", ADDR_LEVEL_CODE, '0);
        chk("off at reset", 3'b000, {act, lp1, lp2});
        $display("test reset done");
        apb(1, ADDR_CONTROL_ZERO, 32'hFFFF_FFFF);
        rdchk("unused bits", ADDR_CONTROL_ZERO, 32'h0000_00BD);
        settle();
        chk("enabled pins", 4'b1111, {act, cons, lp1, lp2});
        chk("pin overrides", 6'h00, {l1o, l1e, l1r, l2o, l2e, l2r});
        for (int p = 0; p < 4; p++) begin
            apb(1, ADDR_CONTROL_ZERO, {24'h00_0000, 4'b1000, 2'(p), 1'b0, 1'(p)});
            settle();
            chk("sources", {2'(p), 1'(p)}, {pos, neg});
        end
        $display("test sources done");
        foreach (rd_codes[i]) begin
            apb(1, ADDR_LEVEL_CODE, {24'h00_0000, rd_codes[i]});
            rdchk("code read", ADDR_LEVEL_CODE, {24'h00_0000, rd_codes[i]});
            chk("code out", rd_codes[i], code);
        end
        $display("test codes done");
        apb(1, ADDR_CONTROL_ZERO, 32'h0000_0030);
        settle();
        chk("disabled pins", 6'b000111, {act, lp1, lp2, l1o, l1e, l1r});
        apb(1, ADDR_CONTROL_ZERO, 32'h0000_0080);
        settle();
        chk("pins released", 5'b00011, {lp1, lp2, l2o, l2e, l2r});
        $display("test pins done");
        apb(1, 12'h010, 32'h0000_00FF);
        chk("unmapped write", 1, err);
        rdchk("unmapped read", 12'h010, '0);
        chk("unmapped read err", 1, err);
        apb(1, ADDR_OPAMP_CTRL, 32'h0000_00FF);
        rdchk("opamp read", ADDR_OPAMP_CTRL, 32'h0000_0080);
        settle();
        chk("opamp on", 1, opa);
        $display("test bus done");
        // generator switched off before sleeping, pins and sources left set
        apb(1, ADDR_CONTROL_ZERO, 32'h0000_0035);
        apb(1, ADDR_SLEEP_CTRL, 32'h0000_0001);
        settle();
        chk("asleep", 1, slp);
        sleep_wake <= 1;
        @(posedge mclk);
        sleep_wake <= 0;
        settle();
        chk("awake", 2'b00, {slp, act});
        rdchk("ctrl0 kept", ADDR_CONTROL_ZERO, 32'h0000_0035);
        $display("test sleep done");
        // level on both pins so the second reset has something to remove
        apb(1, ADDR_CONTROL_ZERO, 32'h0000_00B0);
        settle();
        chk("on before reset", 3'b111, {act, lp1, lp2});
        rst_n <= 0;
        @(posedge mclk);
        rst_n <= 1;
        rdchk("ctrl0 rereset", ADDR_CONTROL_ZERO, '0);
        rdchk("code rereset", ADDR_LEVEL_CODE, '0);
        chk("off rereset", 11'h000, {act, lp1, lp2, code});
        $display("test second reset done");
        report_and_stop();
    end
endmodule // tb
